//--- pkg/sfwp_consts.vh
// Constants of the serial flash write protection block.
// Assumes inclusion by bare name from the design file.
`ifndef SFWP_CONSTS_VH
`define SFWP_CONSTS_VH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define SFWP_A_STAT      8'h00
`define SFWP_A_CTRL      8'h04
`define SFWP_A_OPADR     8'h08
`define SFWP_A_OPINF     8'h0C
`define SFWP_A_REJ       8'h10

// ****************************************************************
// Serial command codes
// ****************************************************************
`define SFWP_C_WEN       8'h06
`define SFWP_C_WDIS      8'h04
`define SFWP_C_WSR       8'h01
`define SFWP_C_PROG      8'h12
`define SFWP_C_SECE      8'h21
`define SFWP_C_BLKE      8'hDC
`define SFWP_C_CHPE      8'hC7
`define SFWP_C_DPD       8'hB9
`define SFWP_C_REL       8'hAB
`define SFWP_C_RSTEN     8'h66
`define SFWP_C_RST       8'h99
`define SFWP_C_OTPIN     8'hB1
`define SFWP_C_OTPOUT    8'hC1
`define SFWP_C_WSEC      8'h2F
`define SFWP_C_QIN       8'h35
`define SFWP_C_QOUT      8'hF5

// ****************************************************************
// Frame lengths in bytes
// ****************************************************************
`define SFWP_N_ONE       9'h001
`define SFWP_N_SR1       9'h002
`define SFWP_N_SR2       9'h003
`define SFWP_N_ERA       9'h005
`define SFWP_N_PGMIN     9'h006
`define SFWP_N_HDR       9'h005
`define SFWP_N_MAX       9'h105

// ****************************************************************
// Status, config, security and control bit positions
// ****************************************************************
`define SFWP_SR_WEL      1
`define SFWP_SR_BPLO     2
`define SFWP_SR_BPHI     5
`define SFWP_SR_QE       6
`define SFWP_SR_SRWD     7
`define SFWP_CF_TB       3
`define SFWP_SEC_FACT    0
`define SFWP_SEC_CUST    1
`define SFWP_CT_FLOCK    0
`define SFWP_CT_HOLD     1

// ****************************************************************
// Protection geometry and one-time area
// ****************************************************************
`define SFWP_BLK_LO      16
`define SFWP_BLK_HI      25
`define SFWP_NBLK        11'h400
`define SFWP_LVL_ALL     4'hB
`define SFWP_OTP_TOP     32'h0000_01FF
`define SFWP_OTP_ESN     32'h0000_000F

// ****************************************************************
// Operation kinds and synchroniser reset levels
// ****************************************************************
`define SFWP_K_PROG      2'h0
`define SFWP_K_SECE      2'h1
`define SFWP_K_BLKE      2'h2
`define SFWP_K_CHPE      2'h3
`define SFWP_SYNC_RST    7'h5A

`endif

//--- design/sfwp_top.v
// Serial flash write protection: command framing and write gating.
// Assumes an APB master on pclk and a serial host whose link pins are
// asynchronous to pclk and slow enough to be sampled (link clock << pclk).
//
// Summary of operation
// - Power-up leaves command machine idle, nothing pending.
// - Act only on frames ending at byte boundary.
// - Change contents only after complete valid frame.
// - Data-changing commands need write latch set.
// - Deep power-down accepts only release, signature, reset.
// - Program or erase on protected block refused.
// - Bottom bit clear: protect top 2^(L-1) blocks.
// - Bottom bit set: protect 2^(L-1) blocks from zero.
// - Levels eleven to fifteen protect whole array.
// - Guard pin low with SRWD set locks level and SRWD.
// - Four-line or quad mode disables pin guarding.
// - Guard pin is data line two; reset pin resets.
// - One-time mode redirects programming to secure area.
// - One-time mode denies main array access.
// - Security bit 0 reports factory lock.
// - Write-security command sets customer lock bit 1.
// - Locks are one-way, cleared only by presetn; locked area stays unchanged.
// - Offsets 000-00F serial number, 010-1FF customer.
// - Protection block is 64K-byte address block.
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_consts.vh"

module sfwp_top #(
  parameter ADDR_W = 32
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output reg               pslverr,
  input  wire              link_clk,
  input  wire              chip_sel_n,
  input  wire              data_io0,
  input  wire              data_io1,
  input  wire              write_guard_n_io2_i,
  output wire              write_guard_n_io2_o,
  output wire              write_guard_n_io2_oe,
  input  wire              data_io3,
  input  wire              hw_reset_n,
  input  wire              factory_lock_strap,
  output reg               op_req,
  output reg  [1:0]        op_kind,
  output reg  [ADDR_W-1:0] op_addr,
  output reg  [8:0]        op_len,
  output reg               op_otp
);

  // ****************************************************************
  // Link pin synchronisers
  // ****************************************************************
  wire [6:0] raw_w;
  reg  [6:0] s1_q;
  reg  [6:0] s2_q;
  reg  [6:0] s3_q;
  reg  [6:0] f_q;
  reg  [6:0] fp_q;
  genvar     gi;
  localparam [6:0] SYNC_RST = `SFWP_SYNC_RST;

  assign raw_w = {hw_reset_n, data_io3, write_guard_n_io2_i, data_io1,
                  data_io0, chip_sel_n, link_clk};

  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[gi] <= SYNC_RST[gi];
          s2_q[gi] <= SYNC_RST[gi];
          s3_q[gi] <= SYNC_RST[gi];
          f_q[gi]  <= SYNC_RST[gi];
          fp_q[gi] <= SYNC_RST[gi];
        end else begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            f_q[gi] <= s3_q[gi];
          end
          fp_q[gi] <= f_q[gi];
        end
      end
    end
  endgenerate

  wire sclk_rise = f_q[0] & ~fp_q[0];
  wire cs_fall   = ~f_q[1] & fp_q[1];
  wire cs_rise   = f_q[1] & ~fp_q[1];
  wire pin_rst   = ~f_q[6];

  // Guard pin is only ever an input here; no read path drives it
  assign write_guard_n_io2_o  = 1'b0;
  assign write_guard_n_io2_oe = 1'b0;

  // ****************************************************************
  // Protection state
  // ****************************************************************
  localparam ST_IDLE  = 2'b01;
  localparam ST_SHIFT = 2'b10;

  reg  [1:0]        st_q;
  reg  [7:0]        sr_q;
  reg  [7:0]        cf_q;
  reg  [1:0]        sec_q;
  reg               dpd_q;
  reg               otp_q;
  reg               quad_q;
  reg               arm_q;
  reg               hold_q;
  reg               strap_done_q;
  reg  [7:0]        sh_q;
  reg  [2:0]        bit_q;
  reg  [8:0]        nb_q;
  reg  [7:0]        cmd_q;
  reg  [ADDR_W-1:0] adr_q;
  reg  [7:0]        b1_q;
  reg  [7:0]        b2_q;
  reg  [15:0]       rej_q;

  wire       four_line = sr_q[`SFWP_SR_QE] | quad_q;
  wire       hw_protect_mode       = sr_q[`SFWP_SR_SRWD] & ~f_q[4]
                         & ~four_line;
  wire [3:0] lvl       = sr_q[`SFWP_SR_BPHI:`SFWP_SR_BPLO];
  wire [2:0] step      = quad_q ? 3'h4 : 3'h1;
  wire [2:0] bit_nx    = bit_q + step;
  wire [7:0] byte_nx   = quad_q ? {sh_q[3:0], f_q[5], f_q[4], f_q[3], f_q[2]}
                                : {sh_q[6:0], f_q[2]};

  // ****************************************************************
  // Block protection lookup
  // ****************************************************************
  function prot_hit;
    input [9:0] blk;
    input [3:0] lv;
    input       tb;
    reg   [10:0] n;
    begin
      n = 11'h001 << (lv - 4'h1);
      if (lv == 4'h0) begin
        prot_hit = 1'b0;
      end else if (lv >= `SFWP_LVL_ALL) begin
        prot_hit = 1'b1;
      end else if (tb) begin
        prot_hit = ({1'b0, blk} < n);
      end else begin
        prot_hit = ({1'b0, blk} >= (`SFWP_NBLK - n));
      end
    end
  endfunction

  wire [9:0] blk_w = adr_q[`SFWP_BLK_HI:`SFWP_BLK_LO];
  wire       blk_prot = prot_hit(blk_w, lvl, cf_q[`SFWP_CF_TB]);

  // ****************************************************************
  // Frame decision at chip-select release
  // ****************************************************************
  reg        fin;
  reg        acc;
  reg        rej;
  reg        set_wel;
  reg        clr_wel;
  reg        go;
  reg [1:0]  kind;
  reg        wr_sr;
  reg        wr_cust;
  reg        soft_rst;
  reg        dpd_set;
  reg        dpd_clr;
  reg        otp_set;
  reg        otp_clr;
  reg        q_set;
  reg        q_clr;
  reg        arm_set;
  reg        otp_bad;
  reg        alter;

  always @* begin
    fin      = cs_rise & (st_q == ST_SHIFT);
    acc      = 1'b0;
    rej      = 1'b0;
    set_wel  = 1'b0;
    clr_wel  = 1'b0;
    go       = 1'b0;
    kind     = `SFWP_K_PROG;
    wr_sr    = 1'b0;
    wr_cust  = 1'b0;
    soft_rst = 1'b0;
    dpd_set  = 1'b0;
    dpd_clr  = 1'b0;
    otp_set  = 1'b0;
    otp_clr  = 1'b0;
    q_set    = 1'b0;
    q_clr    = 1'b0;
    arm_set  = 1'b0;
    alter    = 1'b0;
    otp_bad  = (adr_q > `SFWP_OTP_TOP) | sec_q[`SFWP_SEC_CUST]
               | (sec_q[`SFWP_SEC_FACT] & (adr_q <= `SFWP_OTP_ESN));
    if (fin) begin
      if (bit_q != 3'h0 || nb_q == 9'h000) begin
        rej = 1'b1;
      end else if (dpd_q && cmd_q != `SFWP_C_REL &&
                   cmd_q != `SFWP_C_RSTEN && cmd_q != `SFWP_C_RST) begin
        rej = 1'b1;
      end else begin
        case (cmd_q)
          `SFWP_C_WEN: begin
            acc     = (nb_q == `SFWP_N_ONE);
            set_wel = acc;
          end
          `SFWP_C_WDIS: begin
            acc     = (nb_q == `SFWP_N_ONE);
            clr_wel = acc;
          end
          `SFWP_C_WSR: begin
            acc   = sr_q[`SFWP_SR_WEL] & ~hold_q &
                    (nb_q == `SFWP_N_SR1 || nb_q == `SFWP_N_SR2);
            wr_sr = acc;
            alter = 1'b1;
          end
          `SFWP_C_PROG: begin
            alter = 1'b1;
            if (nb_q >= `SFWP_N_PGMIN && sr_q[`SFWP_SR_WEL] && !hold_q) begin
              acc = otp_q ? ~otp_bad : ~blk_prot;
              go  = acc;
              rej = ~acc;
              clr_wel = 1'b1;
            end
          end
          `SFWP_C_SECE, `SFWP_C_BLKE, `SFWP_C_CHPE: begin
            alter = 1'b1;
            kind  = (cmd_q == `SFWP_C_SECE) ? `SFWP_K_SECE :
                    (cmd_q == `SFWP_C_BLKE) ? `SFWP_K_BLKE : `SFWP_K_CHPE;
            if (((cmd_q == `SFWP_C_CHPE) ? (nb_q == `SFWP_N_ONE)
                                         : (nb_q == `SFWP_N_ERA)) &&
                sr_q[`SFWP_SR_WEL] && !hold_q) begin
              acc = ~otp_q & ((cmd_q == `SFWP_C_CHPE) ? (lvl == 4'h0)
                                                      : ~blk_prot);
              go  = acc;
              rej = ~acc;
              clr_wel = 1'b1;
            end
          end
          `SFWP_C_DPD: begin
            acc     = (nb_q == `SFWP_N_ONE);
            dpd_set = acc;
          end
          `SFWP_C_REL: begin
            acc     = 1'b1;
            dpd_clr = 1'b1;
          end
          `SFWP_C_RSTEN: begin
            acc     = (nb_q == `SFWP_N_ONE);
            arm_set = acc;
          end
          `SFWP_C_RST: begin
            acc      = (nb_q == `SFWP_N_ONE) & arm_q;
            soft_rst = acc;
          end
          `SFWP_C_OTPIN: begin
            acc     = (nb_q == `SFWP_N_ONE);
            otp_set = acc;
          end
          `SFWP_C_OTPOUT: begin
            acc     = (nb_q == `SFWP_N_ONE);
            otp_clr = acc;
          end
          `SFWP_C_WSEC: begin
            alter   = 1'b1;
            acc     = (nb_q == `SFWP_N_ONE) & sr_q[`SFWP_SR_WEL] & ~hold_q;
            wr_cust = acc;
          end
          `SFWP_C_QIN: begin
            acc   = (nb_q == `SFWP_N_ONE);
            q_set = acc;
          end
          `SFWP_C_QOUT: begin
            acc   = (nb_q == `SFWP_N_ONE);
            q_clr = acc;
          end
          default: begin
            acc = 1'b0;
          end
        endcase
        if (!acc) begin
          rej = 1'b1;
        end
        if (alter && acc) begin
          clr_wel = 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Frame capture and state update
  // ****************************************************************
  wire dev_rst = pin_rst | soft_rst;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      sr_q    <= 8'h00;
      cf_q    <= 8'h00;
      dpd_q   <= 1'b0;
      otp_q   <= 1'b0;
      quad_q  <= 1'b0;
      arm_q   <= 1'b0;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      nb_q    <= 9'h000;
      cmd_q   <= 8'h00;
      adr_q   <= {ADDR_W{1'b0}};
      b1_q    <= 8'h00;
      b2_q    <= 8'h00;
      op_req  <= 1'b0;
      op_kind <= `SFWP_K_PROG;
      op_addr <= {ADDR_W{1'b0}};
      op_len  <= 9'h000;
      op_otp  <= 1'b0;
    end else begin
      op_req <= go;
      if (go) begin
        op_kind <= kind;
        op_addr <= adr_q;
        op_len  <= (kind == `SFWP_K_PROG) ? nb_q - `SFWP_N_HDR : 9'h000;
        op_otp  <= otp_q;
      end
      if (dev_rst) begin
        st_q   <= ST_IDLE;
        dpd_q  <= 1'b0;
        otp_q  <= 1'b0;
        quad_q <= 1'b0;
        arm_q  <= 1'b0;
        sr_q[`SFWP_SR_WEL] <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (cs_fall) begin
              st_q  <= ST_SHIFT;
              bit_q <= 3'h0;
              nb_q  <= 9'h000;
            end
          end
          ST_SHIFT: begin
            if (cs_rise) begin
              st_q <= ST_IDLE;
            end else if (sclk_rise) begin
              sh_q  <= byte_nx;
              bit_q <= bit_nx;
              if (bit_nx == 3'h0) begin
                if (nb_q != `SFWP_N_MAX) begin
                  nb_q <= nb_q + 9'h001;
                end
                if (nb_q == 9'h000) begin
                  cmd_q <= byte_nx;
                end
                if (nb_q != 9'h000 && nb_q < `SFWP_N_HDR) begin
                  adr_q <= {adr_q[ADDR_W-9:0], byte_nx};
                end
                if (nb_q == `SFWP_N_ONE) begin
                  b1_q <= byte_nx;
                end
                if (nb_q == `SFWP_N_SR1) begin
                  b2_q <= byte_nx;
                end
              end
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
        if (fin) begin
          arm_q <= arm_set;
        end
        if (set_wel) begin
          sr_q[`SFWP_SR_WEL] <= 1'b1;
        end else if (clr_wel) begin
          sr_q[`SFWP_SR_WEL] <= 1'b0;
        end
        if (wr_sr) begin
          sr_q[`SFWP_SR_QE] <= b1_q[`SFWP_SR_QE];
          if (!hw_protect_mode) begin
            sr_q[`SFWP_SR_SRWD] <= b1_q[`SFWP_SR_SRWD];
            sr_q[`SFWP_SR_BPHI:`SFWP_SR_BPLO] <=
              b1_q[`SFWP_SR_BPHI:`SFWP_SR_BPLO];
          end
          if (nb_q == `SFWP_N_SR2) begin
            cf_q <= b2_q;
          end
        end
        if (dpd_set) begin
          dpd_q <= 1'b1;
        end else if (dpd_clr) begin
          dpd_q <= 1'b0;
        end
        if (otp_set) begin
          otp_q <= 1'b1;
        end else if (otp_clr) begin
          otp_q <= 1'b0;
        end
        if (q_set) begin
          quad_q <= 1'b1;
        end else if (q_clr) begin
          quad_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Security locks, one-way
  // ****************************************************************
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q        <= 2'b00;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q && factory_lock_strap) begin
        sec_q[`SFWP_SEC_FACT] <= 1'b1;
      end
      if (apb_wr && paddr == `SFWP_A_CTRL && pwdata[`SFWP_CT_FLOCK]) begin
        sec_q[`SFWP_SEC_FACT] <= 1'b1;
      end
      if (wr_cust) begin
        sec_q[`SFWP_SEC_CUST] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign pready = 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
      rej_q  <= 16'h0000;
    end else begin
      if (apb_wr && paddr == `SFWP_A_CTRL) begin
        hold_q <= pwdata[`SFWP_CT_HOLD];
      end
      if (rej && rej_q != 16'hFFFF) begin
        rej_q <= rej_q + 16'h0001;
      end else if (apb_wr && paddr == `SFWP_A_REJ) begin
        rej_q <= 16'h0000;
      end
    end
  end

  always @* begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `SFWP_A_STAT: prdata = {10'h000, hw_protect_mode, quad_q, otp_q, dpd_q,
                              sec_q, cf_q, sr_q};
      `SFWP_A_CTRL: prdata = {30'h0000_0000, hold_q, sec_q[`SFWP_SEC_FACT]};
      `SFWP_A_OPADR: prdata = op_addr[31:0];
      `SFWP_A_OPINF: prdata = {20'h00000, op_otp, op_kind, op_len};
      `SFWP_A_REJ:  prdata = {16'h0000, rej_q};
      default: begin
        pslverr = psel & penable;
        prdata  = 32'h0000_0000;
      end
    endcase
    if (!apb_rd) begin
      prdata = 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

//--- sim/sfwp_props_properties.sv
// Port checker of the write protection block.
// Assumes it is bound onto sfwp_top.
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_consts.vh"
module sfwp_props #(
  parameter ADDR_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              chip_sel_n,
  input wire logic              write_guard_n_io2_oe,
  input wire logic              write_guard_n_io2_o,
  input wire logic              op_req,
  input wire logic [1:0]        op_kind,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [8:0]        op_len,
  input wire logic              op_otp
);
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_busy;
    chip_sel_n ##1 !chip_sel_n [*3];
  endsequence
  property p_rdy;
    s_acc |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_idle;
    !(psel && penable) |-> prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_pulse;
    op_req |=> !op_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_end;
    op_req |-> chip_sel_n && $past(chip_sel_n, 2);
  endproperty
  a_end: assert property (p_end) else $error("op in frame");
  property p_frame;
    s_busy |-> !op_req;
  endproperty
  a_frame: assert property (p_frame) else $error("op mid frame");
  property p_len;
    op_req && op_kind == `SFWP_K_PROG |-> op_len inside {[9'h001:9'h100]};
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_era;
    op_req && op_kind != `SFWP_K_PROG |-> op_len == 9'h000 && !op_otp;
  endproperty
  a_era: assert property (p_era) else $error("bad erase");
  property p_otp;
    op_req && op_otp |-> op_addr <= `SFWP_OTP_TOP;
  endproperty
  a_otp: assert property (p_otp) else $error("otp range");
  property p_hold;
    !op_req |-> $stable(op_addr) && $stable(op_kind) && $stable(op_len);
  endproperty
  a_hold: assert property (p_hold) else $error("op moved");
  property p_pin;
    !write_guard_n_io2_oe && !write_guard_n_io2_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven");
endmodule
bind sfwp_top sfwp_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chip_sel_n(chip_sel_n), .write_guard_n_io2_oe(write_guard_n_io2_oe),
  .write_guard_n_io2_o(write_guard_n_io2_o),
  .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr),
  .op_len(op_len), .op_otp(op_otp));
`default_nettype wire

//--- sim/sfwp_host.sv
// Serial host model: sends single line frames, clock idles low.
// Assumes the bench calls frame() and sets guard_lvl.
`timescale 1ns/1ps
`default_nettype none
module sfwp_host (
  output logic      link_clk,
  output logic      chip_sel_n,
  output logic      io0,
  output logic      io1,
  output logic      io2,
  output logic      io3,
  input  wire logic guard_lvl
);
  // ****
  // Frame driver
  // ****
  initial begin
    link_clk = 1'b0;
    chip_sel_n = 1'b1;
    io0 = 1'b0;
  end
  assign io1 = ~io0;
  assign io3 = io0;
  assign io2 = guard_lvl;
  task automatic frame(input logic [7:0] b [$], input int n);
    chip_sel_n = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      io0 = b[i/8][7-i%8];
      #80 link_clk = 1'b1;
      #160 link_clk = 1'b0;
      #80;
    end
    #160 chip_sel_n = 1'b1;
    io0 = ~io0;
    #1200;
  endtask
endmodule
`default_nettype wire

//--- sim/sfwp_top_bench.sv
// Bench of the write protection block: APB master and host model.
// Assumes sfwp_top, sfwp_host and the constant header.
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_consts.vh"
module sfwp_top_bench;
  logic        pclk, presetn, psel, penable, pwrite, e, guard_lvl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, op_addr;
  logic        pready, pslverr, link_clk, chip_sel_n, io0, io1, io2, io3;
  logic        hw_reset_n, op_req, op_otp, strap;
  logic [1:0]  op_kind;
  logic [8:0]  op_len;
  int          fail_count, checks, ops, n0;
  typedef struct packed {
    logic [3:0] lv;
    logic       tb;
    logic [9:0] blk;
    logic       ok;
  } sfwp_row_t;
  sfwp_row_t rows [13] = '{'{4'h1, 1'b0, 10'h3FF, 1'b0},
    '{4'h1, 1'b0, 10'h3FE, 1'b1}, '{4'h3, 1'b0, 10'h3FC, 1'b0},
    '{4'h3, 1'b0, 10'h3FB, 1'b1}, '{4'hA, 1'b0, 10'h200, 1'b0},
    '{4'hA, 1'b0, 10'h1FF, 1'b1}, '{4'h1, 1'b1, 10'h000, 1'b0},
    '{4'h1, 1'b1, 10'h001, 1'b1}, '{4'hA, 1'b1, 10'h1FF, 1'b0},
    '{4'hA, 1'b1, 10'h200, 1'b1}, '{4'hB, 1'b1, 10'h000, 1'b0},
    '{4'hF, 1'b0, 10'h001, 1'b0}, '{4'h0, 1'b0, 10'h3FF, 1'b1}};

  sfwp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .chip_sel_n(chip_sel_n), .data_io0(io0),
    .data_io1(io1), .write_guard_n_io2_i(io2), .write_guard_n_io2_o(),
    .write_guard_n_io2_oe(), .data_io3(io3), .hw_reset_n(hw_reset_n),
    .factory_lock_strap(strap), .op_req(op_req), .op_kind(op_kind),
    .op_addr(op_addr), .op_len(op_len), .op_otp(op_otp));
  sfwp_host u_host (.link_clk(link_clk), .chip_sel_n(chip_sel_n),
    .io0(io0), .io1(io1), .io2(io2), .io3(io3), .guard_lvl(guard_lvl));

  // ****
  // Clock, counters and tasks
  // ****
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (op_req === 1'b1)
      ops <= ops + 1;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      wrap_up;
    end
  endtask
  task automatic st;
    apb(1'b0, `SFWP_A_STAT, 32'h0);
  endtask
  task automatic tx(input logic [7:0] b [$]);
    u_host.frame(b, b.size() * 8);
  endtask
  task automatic wen;
    tx('{`SFWP_C_WEN});
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] a, input int d);
    logic [7:0] q [$];
    q = '{c, a[31:24], a[23:16], a[15:8], a[7:0]};
    repeat (d) q.push_back(8'hA5);
    tx(q);
  endtask
  task automatic wsr(input logic [7:0] s, input logic [7:0] c);
    wen;
    tx('{`SFWP_C_WSR, s, c});
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (50000) @(posedge pclk);
    fail_count++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {hw_reset_n, guard_lvl, strap, fail_count, checks, ops} = '0;
    hw_reset_n = 1'b1;
    guard_lvl = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    st;
    chk(r, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    cmd(`SFWP_C_PROG, 32'h0012_3400, 1);
    chk(ops, 0);
    wen;
    st;
    chk(r[1], 1'b1);
    cmd(`SFWP_C_PROG, 32'h0012_3400, 2);
    chk(ops, 1);
    chk({op_otp, op_kind, op_len}, {1'b0, `SFWP_K_PROG, 9'h002});
    chk(op_addr, 32'h0012_3400);
    u_host.frame('{`SFWP_C_WEN}, 7);
    u_host.frame('{`SFWP_C_WEN, 8'h00}, 9);
    st;
    chk(r[1], 1'b0);
    foreach (rows[i]) begin
      wsr({2'h0, rows[i].lv, 2'h0}, {4'h0, rows[i].tb, 3'h0});
      st;
      chk(r[5:2], rows[i].lv);
      wen;
      n0 = ops;
      cmd(`SFWP_C_SECE, {6'h00, rows[i].blk, 16'h0000}, 0);
      chk(ops - n0, rows[i].ok);
      st;
      chk(r[1], 1'b0);
    end
    wen;
    cmd(`SFWP_C_BLKE, 32'h0001_0000, 0);
    chk(op_kind, `SFWP_K_BLKE);
    wen;
    tx('{`SFWP_C_CHPE});
    chk(op_kind, `SFWP_K_CHPE);
    wsr(8'h00, 8'h00);
    tx('{`SFWP_C_DPD});
    wen;
    st;
    chk({r[18], r[1]}, 2'h2);
    tx('{`SFWP_C_REL});
    wen;
    st;
    chk({r[18], r[1]}, 2'h1);
    tx('{`SFWP_C_WDIS});
    st;
    chk(r[1], 1'b0);
    wen;
    tx('{`SFWP_C_OTPIN});
    tx('{`SFWP_C_DPD});
    tx('{`SFWP_C_RSTEN});
    tx('{`SFWP_C_RST});
    st;
    chk({r[19:18], r[1]}, 3'h0);
    wsr(8'h80, 8'h00);
    guard_lvl <= 1'b0;
    wsr(8'h94, 8'h00);
    st;
    chk({r[21], r[7:2]}, 7'h60);
    wsr(8'hC4, 8'h00);
    wsr(8'hC4, 8'h00);
    st;
    chk({r[21], r[7:2]}, 7'h31);
    guard_lvl <= 1'b1;
    wsr(8'h00, 8'h00);
    tx('{`SFWP_C_OTPIN});
    st;
    chk(r[19], 1'b1);
    n0 = ops;
    wen;
    cmd(`SFWP_C_PROG, 32'h0000_0010, 1);
    chk({op_otp, op_addr}, {1'b1, 32'h0000_0010});
    wen;
    cmd(`SFWP_C_PROG, 32'h0000_0200, 1);
    wen;
    cmd(`SFWP_C_SECE, 32'h0000_0000, 0);
    chk(ops - n0, 1);
    tx('{`SFWP_C_OTPOUT});
    wen;
    tx('{`SFWP_C_WSEC});
    st;
    chk(r[17:16], 2'h2);
    tx('{`SFWP_C_QIN});
    st;
    chk(r[20], 1'b1);
    apb(1'b1, `SFWP_A_CTRL, 32'h0000_0001);
    hw_reset_n <= 1'b0;
    repeat (10) @(posedge pclk);
    hw_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
    st;
    chk(r[20:16], 5'h03);
    tx('{`SFWP_C_OTPIN});
    n0 = ops;
    wen;
    cmd(`SFWP_C_PROG, 32'h0000_0010, 1);
    chk(ops - n0, 0);
    strap <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    st;
    chk(r, 32'h0001_0000);
    chk({op_otp, op_kind, op_len}, 12'h000);
    wrap_up;
  end
endmodule
`default_nettype wire
